// file: verilog/bsls_cfg.svh
`ifndef BSLS_CFG_SVH
`define BSLS_CFG_SVH

// ****************************************
// flag positions
// ****************************************
`define BSLS_F_C 3'h0
`define BSLS_F_Z 3'h1
`define BSLS_F_N 3'h2
`define BSLS_F_V 3'h3
`define BSLS_F_S 3'h4
`define BSLS_F_H 3'h5
`define BSLS_F_T 3'h6
`define BSLS_F_I 3'h7

// ****************************************
// map, resets, counts
// ****************************************
`define BSLS_PTR_BASE 5'h1A
`define BSLS_A_FLAGS  6'h20
`define BSLS_A_SP_LO  6'h21
`define BSLS_A_SP_HI  6'h22
`define BSLS_A_STAT   6'h23
`define BSLS_SP_RST   16'h03FF
`define BSLS_FLG_RST  8'h00
`define BSLS_NVM_BASE 16'h4000
`define BSLS_PC_W     22
`define BSLS_N_LDS    3'h3
`define BSLS_N_LDP    3'h2
`define BSLS_N_STS    3'h2
`define BSLS_N_STP    3'h1
`define BSLS_N_JMPI   3'h2
`define BSLS_N_BR     3'h2
`define BSLS_N_ONE    3'h1
`endif

// file: verilog/bsls_pkg.sv
package bsls_pkg;
   typedef enum logic [4:0] {
      op_equal_skip_compare = 5'h00, op_skip_if_reg_bit_low = 5'h01,
      op_skip_if_reg_bit_high = 5'h02, op_skip_if_io_bit_low = 5'h03,
      op_skip_if_io_bit_high = 5'h04, op_branch_on_flag_high = 5'h05,
      op_branch_on_flag_low = 5'h06, op_compare_registers = 5'h07,
      op_compare_with_carry_in = 5'h08, op_compare_with_constant = 5'h09,
      op_register_copy = 5'h0A, op_register_pair_copy = 5'h0B,
      op_constant_load = 5'h0C, op_load_absolute = 5'h0D,
      op_load_via_pointer = 5'h0E, op_load_pointer_offset = 5'h0F,
      op_write_absolute = 5'h10, op_write_via_pointer = 5'h11,
      op_write_pointer_offset = 5'h12, op_call_absolute = 5'h13,
      op_subroutine_exit = 5'h14, op_interrupt_exit = 5'h15,
      op_pointer_jump = 5'h16, op_pointer_subroutine_jump = 5'h17,
      op_nop = 5'h18
   } bsls_op_t;
   typedef enum logic [1:0] {
      pm_plain = 2'h0, pm_post_inc = 2'h1, pm_pre_dec = 2'h2
   } bsls_pm_t;
   typedef struct packed {
      logic [31:0][7:0] gpr;
      logic [7:0]       flg;
      logic [15:0]      sp;
      logic [21:0]      pc;
      logic             busy;
      logic [2:0]       step;
      logic [2:0]       len;
      bsls_op_t         op;
      logic [4:0]       rd;
      logic [4:0]       rr;
      logic [2:0]       bsel;
      logic [7:0]       imm;
      logic [21:0]      kadr;
      logic [6:0]       koff;
      logic [5:0]       q;
      logic [1:0]       psel;
      bsls_pm_t         pm;
      logic             nxt2;
      logic [15:0]      ea;
      logic             hold;
      logic [23:0]      ret;
      logic [7:0]       rdat;
      logic             done;
   } bsls_st_t;
endpackage : bsls_pkg

// file: verilog/bsls_exec.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "bsls_cfg.svh"
module bsls_exec
   import bsls_pkg::*;
#(
   parameter int          PC_W     = `BSLS_PC_W,
   parameter logic [15:0] NVM_BASE = `BSLS_NVM_BASE
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        instr_valid,
   output wire logic        instr_ready,
   input  wire bsls_op_t    instr_op,
   input  wire logic [4:0]  instr_rd,
   input  wire logic [4:0]  instr_rr,
   input  wire logic [2:0]  instr_bit,
   input  wire logic [7:0]  instr_imm,
   input  wire logic [21:0] instr_addr,
   input  wire logic [6:0]  instr_off,
   input  wire logic [5:0]  instr_disp,
   input  wire logic [1:0]  instr_ptr,
   input  wire bsls_pm_t    instr_pm,
   input  wire logic        instr_next_long,
   output wire logic        instr_done,
   output wire logic [21:0] pc_out,
   output wire logic        dmem_req,
   output wire logic        dmem_we,
   output wire logic [15:0] dmem_addr,
   output wire logic [7:0]  dmem_wdata,
   input  wire logic [7:0]  dmem_rdata,
   input  wire logic        dmem_ack,
   output wire logic        io_re,
   output wire logic [4:0]  io_addr,
   input  wire logic [7:0]  io_rdata,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output wire logic [7:0]  reg_rdata
);
   // ****************************************
   // widths
   // ****************************************
   localparam logic [21:0] PCM = 22'h3FFFFF >> (22 - PC_W);
   // return address bytes on the stack
   localparam logic [2:0]  NB  = (PC_W > 16) ? 3'h3 : 3'h2;

   bsls_st_t    st_q;
   bsls_st_t    st_d;
   logic        mreq;
   logic        mwe;
   logic [15:0] maddr;
   logic [7:0]  mwd;
   logic        iore;
   logic [4:0]  pl;
   logic [15:0] ptr;
   logic [15:0] zp;
   logic [7:0]  a;
   logic [7:0]  b;
   logic        cin;
   logic [8:0]  dif;
   logic [4:0]  hd;
   logic        fl;
   logic        cnd;
   logic        lng;
   logic [21:0] pinc;
   logic [21:0] pskp;
   logic [21:0] btgt;
   logic [15:0] ea_now;
   logic [15:0] ea;
   logic        nv;
   logic        dld;
   logic        dst;
   logic        skp;
   logic        brn;
   logic        first;
   logic [2:0]  ln;
   logic [2:0]  len;
   logic        last;
   logic        stall;
   logic        fin;
   logic [2:0]  bi;
   logic [23:0] r24;

   // ****************************************
   // operand and condition decode
   // ****************************************
   always_comb begin
      pl = `BSLS_PTR_BASE + {2'h0, st_q.psel, 1'b0};
      ptr = {st_q.gpr[pl | 5'h01], st_q.gpr[pl]};
      zp = {st_q.gpr[5'h1F], st_q.gpr[5'h1E]};
      a = st_q.gpr[st_q.rd];
      b = (st_q.op == op_compare_with_constant) ? st_q.imm : st_q.gpr[st_q.rr];
      cin = (st_q.op == op_compare_with_carry_in) & st_q.flg[`BSLS_F_C];
      dif = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      hd = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      // s is evaluated from n and v so signed branches follow the arithmetic
      fl = (st_q.bsel == `BSLS_F_S) ?
           (st_q.flg[`BSLS_F_N] ^ st_q.flg[`BSLS_F_V]) :
           st_q.flg[st_q.bsel];
      lng = (st_q.op == op_load_absolute) | (st_q.op == op_write_absolute) |
            (st_q.op == op_call_absolute);
      pinc = (st_q.pc + (lng ? 22'h2 : 22'h1)) & PCM;
      pskp = (st_q.pc + (st_q.nxt2 ? 22'h3 : 22'h2)) & PCM;
      btgt = (st_q.pc + {{15{st_q.koff[6]}}, st_q.koff} + 22'h1) & PCM;
      cnd = 1'b0;
      case (st_q.op) inside
         op_equal_skip_compare:   cnd = (a == st_q.gpr[st_q.rr]);
         op_skip_if_reg_bit_low:  cnd = !st_q.gpr[st_q.rr][st_q.bsel];
         op_skip_if_reg_bit_high: cnd = st_q.gpr[st_q.rr][st_q.bsel];
         op_skip_if_io_bit_low:   cnd = !io_rdata[st_q.bsel];
         op_skip_if_io_bit_high:  cnd = io_rdata[st_q.bsel];
         op_branch_on_flag_high:  cnd = fl;
         op_branch_on_flag_low:   cnd = !fl;
         default:                 cnd = 1'b0;
      endcase
      skp = (st_q.op inside {op_equal_skip_compare, op_skip_if_reg_bit_low,
             op_skip_if_reg_bit_high, op_skip_if_io_bit_low, op_skip_if_io_bit_high});
      brn = (st_q.op inside {op_branch_on_flag_high, op_branch_on_flag_low});
      dld = (st_q.op inside {op_load_absolute, op_load_via_pointer, op_load_pointer_offset});
      dst = (st_q.op inside {op_write_absolute, op_write_via_pointer, op_write_pointer_offset});
      case (st_q.op) inside
         op_load_absolute:  ea_now = st_q.kadr[15:0];
         op_write_absolute: ea_now = st_q.kadr[15:0];
         op_load_pointer_offset, op_write_pointer_offset:
            ea_now = ptr + {10'h000, st_q.q};
         op_load_via_pointer, op_write_via_pointer:
            ea_now = (st_q.pm == pm_pre_dec) ? ptr - 16'h0001 : ptr;
         default:           ea_now = st_q.ea;
      endcase
      case (st_q.op) inside
         op_equal_skip_compare, op_skip_if_reg_bit_low, op_skip_if_reg_bit_high,
         op_skip_if_io_bit_low, op_skip_if_io_bit_high:
            ln = cnd ? (st_q.nxt2 ? 3'h3 : 3'h2) : `BSLS_N_ONE;
         op_branch_on_flag_high, op_branch_on_flag_low:
            ln = cnd ? `BSLS_N_BR : `BSLS_N_ONE;
         op_load_absolute:           ln = `BSLS_N_LDS;
         op_load_via_pointer, op_load_pointer_offset:
                                     ln = `BSLS_N_LDP;
         op_write_absolute:          ln = `BSLS_N_STS;
         op_write_via_pointer, op_write_pointer_offset:
                                     ln = `BSLS_N_STP;
         op_call_absolute:           ln = NB + 3'h1;
         op_subroutine_exit, op_interrupt_exit:
                                     ln = NB + 3'h2;
         op_pointer_jump:            ln = `BSLS_N_JMPI;
         op_pointer_subroutine_jump: ln = NB;
         default:                    ln = `BSLS_N_ONE;
      endcase
      first = (st_q.step == 3'h1) & !st_q.hold;
      len = first ? ln : st_q.len;
      ea = first ? ea_now : st_q.ea;
      nv = (ea >= NVM_BASE);
      last = (st_q.step == len);
      // the ack is not honoured in the first waiting cycle
      stall = (dld | dst) & last & nv & !(st_q.hold & dmem_ack);
      fin = st_q.busy & last & !stall;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      mreq = 1'b0;
      mwe = 1'b0;
      maddr = ea;
      mwd = 8'h00;
      iore = 1'b0;
      bi = 3'h0;
      r24 = {2'h0, pinc};
      if (reg_re) begin
         if (!reg_addr[5]) begin
            st_d.rdat = st_q.gpr[reg_addr[4:0]];
         end else begin
            case (reg_addr)
               `BSLS_A_FLAGS: st_d.rdat = st_q.flg;
               `BSLS_A_SP_LO: st_d.rdat = st_q.sp[7:0];
               `BSLS_A_SP_HI: st_d.rdat = st_q.sp[15:8];
               `BSLS_A_STAT:  st_d.rdat = {6'h00, st_q.hold, st_q.busy};
               default:       st_d.rdat = 8'h00;
            endcase
         end
      end
      // software writes only land while no instruction is in flight
      if (reg_we && !st_q.busy) begin
         if (!reg_addr[5]) begin
            st_d.gpr[reg_addr[4:0]] = reg_wdata;
         end else begin
            case (reg_addr)
               `BSLS_A_FLAGS: st_d.flg = reg_wdata;
               `BSLS_A_SP_LO: st_d.sp[7:0] = reg_wdata;
               `BSLS_A_SP_HI: st_d.sp[15:8] = reg_wdata;
               default:       st_d.rdat = st_d.rdat;
            endcase
         end
      end
      if (!st_q.busy) begin
         if (instr_valid) begin
            st_d.busy = 1'b1;
            st_d.step = 3'h1;
            st_d.hold = 1'b0;
            st_d.op = instr_op;
            st_d.rd = instr_rd;
            st_d.rr = instr_rr;
            st_d.bsel = instr_bit;
            st_d.imm = instr_imm;
            st_d.kadr = instr_addr;
            st_d.koff = instr_off;
            st_d.q = instr_disp;
            st_d.psel = instr_ptr;
            st_d.pm = instr_pm;
            st_d.nxt2 = instr_next_long;
            st_d.ret = 24'h000000;
         end
      end else begin
         if (first) begin
            st_d.len = ln;
            st_d.ea = ea_now;
            iore = (st_q.op inside {op_skip_if_io_bit_low, op_skip_if_io_bit_high});
            if (skp) begin
               st_d.pc = cnd ? pskp : pinc;
            end
            if (brn) begin
               st_d.pc = cnd ? btgt : pinc;
            end
            case (st_q.op) inside
               op_compare_registers, op_compare_with_carry_in, op_compare_with_constant: begin
                  st_d.flg[`BSLS_F_Z] = (dif[7:0] == 8'h00) &
                     ((st_q.op != op_compare_with_carry_in) | st_q.flg[`BSLS_F_Z]);
                  st_d.flg[`BSLS_F_C] = dif[8];
                  st_d.flg[`BSLS_F_N] = dif[7];
                  st_d.flg[`BSLS_F_V] = (a[7] & !b[7] & !dif[7]) | (!a[7] & b[7] & dif[7]);
                  st_d.flg[`BSLS_F_S] = dif[7] ^ st_d.flg[`BSLS_F_V];
                  st_d.flg[`BSLS_F_H] = hd[4];
               end
               op_register_copy: st_d.gpr[st_q.rd] = st_q.gpr[st_q.rr];
               op_register_pair_copy: begin
                  st_d.gpr[st_q.rd & 5'h1E] = st_q.gpr[st_q.rr & 5'h1E];
                  st_d.gpr[st_q.rd | 5'h01] = st_q.gpr[st_q.rr | 5'h01];
               end
               op_constant_load: st_d.gpr[st_q.rd] = st_q.imm;
               op_load_via_pointer, op_write_via_pointer: begin
                  if (st_q.pm == pm_post_inc) begin
                     {st_d.gpr[pl | 5'h01], st_d.gpr[pl]} = ptr + 16'h0001;
                  end else if (st_q.pm == pm_pre_dec) begin
                     {st_d.gpr[pl | 5'h01], st_d.gpr[pl]} = ptr - 16'h0001;
                  end
               end
               default: st_d.hold = st_q.hold;
            endcase
         end
         if (dld && (st_q.step == len - 3'h1)) begin
            mreq = 1'b1;
         end
         if (dst && last && !st_q.hold) begin
            mreq = 1'b1;
            mwe = 1'b1;
            mwd = st_q.gpr[st_q.rr];
         end
         if (stall) begin
            st_d.hold = 1'b1;
         end
         if (dld && fin) begin
            st_d.gpr[st_q.rd] = dmem_rdata;
         end
         // pushes run low byte first, so the top of stack is the high byte
         if (st_q.op == op_call_absolute && st_q.step >= 3'h2) begin
            bi = st_q.step - 3'h2;
         end else begin
            bi = st_q.step - 3'h1;
         end
         if ((st_q.op == op_call_absolute && st_q.step >= 3'h2) ||
             st_q.op == op_pointer_subroutine_jump) begin
            mreq = 1'b1;
            mwe = 1'b1;
            maddr = st_q.sp;
            mwd = r24[{bi[1:0], 3'h0} +: 8];
            st_d.sp = st_q.sp - 16'h0001;
         end
         if (st_q.op inside {op_subroutine_exit, op_interrupt_exit}) begin
            if (st_q.step <= NB) begin
               mreq = 1'b1;
               maddr = st_q.sp + 16'h0001;
               st_d.sp = st_q.sp + 16'h0001;
            end
            if (st_q.step >= 3'h2 && st_q.step <= NB + 3'h1) begin
               bi = NB + 3'h1 - st_q.step;
               st_d.ret[{bi[1:0], 3'h0} +: 8] = dmem_rdata;
            end
         end
         if (fin) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
            st_d.step = 3'h0;
            st_d.hold = 1'b0;
            case (st_q.op) inside
               op_equal_skip_compare, op_skip_if_reg_bit_low, op_skip_if_reg_bit_high,
               op_skip_if_io_bit_low, op_skip_if_io_bit_high,
               op_branch_on_flag_high, op_branch_on_flag_low:
                  st_d.pc = st_d.pc;
               op_call_absolute:   st_d.pc = st_q.kadr & PCM;
               op_subroutine_exit: st_d.pc = st_q.ret[21:0] & PCM;
               op_interrupt_exit: begin
                  st_d.pc = st_q.ret[21:0] & PCM;
                  st_d.flg[`BSLS_F_I] = 1'b1;
               end
               op_pointer_jump, op_pointer_subroutine_jump:
                  st_d.pc = {6'h00, zp} & PCM;
               default:            st_d.pc = pinc;
            endcase
         end else if (!stall) begin
            st_d.step = st_q.step + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= '0;
         st_q.sp <= `BSLS_SP_RST;
         st_q.flg <= `BSLS_FLG_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign instr_ready = !st_q.busy;
   assign instr_done  = st_q.done;
   assign pc_out      = st_q.pc;
   assign dmem_req    = mreq;
   assign dmem_we     = mwe;
   assign dmem_addr   = maddr;
   assign dmem_wdata  = mwd;
   assign io_re       = iore;
   assign io_addr     = st_q.kadr[4:0];
   assign reg_rdata   = st_q.rdat;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic acc_lds;
   assign acc_lds = !st_q.busy & instr_valid & (instr_op == op_load_absolute) &
                    (instr_addr[15:0] < NVM_BASE);

   a_skip_pc: assert property (st_q.busy && first && skp && cnd |=> st_q.pc == $past(pskp))
      else $error("skip target wrong");
   a_skip_len: assert property (st_q.busy && first && skp && cnd && st_q.nxt2
      |-> !fin ##1 !fin ##1 fin) else $error("long skip not three cycles");
   a_skip_flags: assert property (st_q.busy && skp |=> $stable(st_q.flg))
      else $error("skip changed flags");
   a_br_taken: assert property (st_q.busy && first && brn && cnd
      |=> st_q.pc == $past(btgt) ##0 fin) else $error("taken branch wrong");
   a_br_not: assert property (st_q.busy && first && brn && !cnd |-> fin)
      else $error("untaken branch not one cycle");
   a_cmp_nowr: assert property (st_q.busy && (st_q.op == op_compare_registers)
      |=> $stable(st_q.gpr)) else $error("compare wrote register");
   a_lds_len: assert property (acc_lds |=> st_q.busy [*3] ##1 !st_q.busy)
      else $error("absolute load not three cycles");
   a_ptr_post: assert property (st_q.busy && first && dld && (st_q.pm == pm_post_inc) &&
      (st_q.op == op_load_via_pointer) |=> ptr == $past(ptr) + 16'h0001)
      else $error("pointer not incremented");
   a_nvm_extra: assert property (mreq && mwe && dst && nv && !st_q.hold |-> !fin)
      else $error("nvm write finished early");
   a_jmp_z: assert property (fin && (st_q.op == op_pointer_jump)
      |=> st_q.pc == ({6'h00, $past(zp)} & PCM)) else $error("pointer jump target wrong");
   a_interrupt_exit_i: assert property (fin && (st_q.op == op_interrupt_exit) |=> st_q.flg[`BSLS_F_I])
      else $error("interrupt exit left i clear");

   c_skip_long: cover property (st_q.busy && first && skp && cnd && st_q.nxt2);
   c_br_taken: cover property (st_q.busy && first && brn && cnd);
   c_nvm_load: cover property (fin && dld && nv);
   c_ret_done: cover property (fin && (st_q.op == op_subroutine_exit));
endmodule : bsls_exec

// file: dv/bsls_mem_model.sv
// ********
// data memory and i/o space seen by the core
// ********
module bsls_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        dmem_req,
   input  wire logic        dmem_we,
   input  wire logic [15:0] dmem_addr,
   input  wire logic [7:0]  dmem_wdata,
   output logic      [7:0]  dmem_rdata,
   output logic             dmem_ack,
   input  wire logic        io_re,
   input  wire logic [7:0]  io_val,
   output logic      [7:0]  io_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem_q [256];
   logic [7:0] dat_q;
   logic       vld_q;
   logic [1:0] wait_q;
   // idle buses show inverted data so a stale sample never matches
   assign dmem_rdata = (vld_q || dmem_ack) ? dat_q : ~dat_q;
   assign dmem_ack   = (wait_q == 2'h1);
   assign io_rdata   = io_re ? io_val : ~io_val;
   always @(posedge clk_sys) begin
      vld_q <= dmem_req && !dmem_we && dmem_addr < 16'h4000;
      if (dmem_req) begin
         dat_q <= mem_q[dmem_addr[7:0]];
      end
      if (dmem_req && dmem_we) begin
         mem_q[dmem_addr[7:0]] <= dmem_wdata;
      end
      // nvm space answers two cycles late to stretch the access
      if (dmem_req && dmem_addr >= 16'h4000) begin
         wait_q <= 2'h2;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end
   end
   initial wait_q = 2'h0;
endmodule : bsls_mem_model

// file: dv/branch_skip_load_store_exec_test.sv
module branch_skip_load_store_exec_test;
   import bsls_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 0, rst = 1, instr_valid = 0, nlong = 0, reg_we = 0, reg_re = 0;
   logic        instr_ready, instr_done, dmem_req, dmem_we, dmem_ack, io_re;
   bsls_op_t    op = op_nop;
   bsls_pm_t    pm = pm_plain;
   logic [4:0]  rd = 0, rr = 0, io_addr;
   logic [2:0]  bt = 0;
   logic [7:0]  imm = 0, io_val = 0, reg_wdata = 0, dmem_wdata, dmem_rdata, io_rdata, reg_rdata;
   logic [21:0] adr = 0, pc_out, epc;
   logic [6:0]  off = 0;
   logic [5:0]  disp = 0, reg_addr = 0;
   logic [1:0]  ptr = 0;
   logic [15:0] dmem_addr;
   int          fails = 0, total_checks = 0, cyc = 0, n;
   bsls_exec u_dut (.clk_sys, .rst, .instr_valid, .instr_ready, .instr_op(op), .instr_rd(rd),
      .instr_rr(rr), .instr_bit(bt), .instr_imm(imm), .instr_addr(adr), .instr_off(off),
      .instr_disp(disp), .instr_ptr(ptr), .instr_pm(pm), .instr_next_long(nlong), .instr_done,
      .pc_out, .dmem_req, .dmem_we, .dmem_addr, .dmem_wdata, .dmem_rdata, .dmem_ack, .io_re,
      .io_addr, .io_rdata, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
   bsls_mem_model u_mem (.clk_sys, .dmem_req, .dmem_we, .dmem_addr, .dmem_wdata, .dmem_rdata,
      .dmem_ack, .io_re, .io_val, .io_rdata);
   always #20 clk_sys = ~clk_sys;
   // ********
   // shared tasks
   // ********
   task results;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1;
      @(posedge clk_sys);
      reg_we <= 0;
   endtask : wr
   task rdc(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_re <= 1;
      @(posedge clk_sys);
      reg_re <= 0;
      #1 chk(reg_rdata, e);
   endtask : rdc
   // leaves n holding the cycles from take to done
   task go(input bsls_op_t o);
      @(posedge clk_sys);
      op <= o;
      instr_valid <= 1;
      @(posedge clk_sys);
      instr_valid <= 0;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1 n++;
      end while (instr_done !== 1'b1 && n < 30);
   endtask : go
   // ********
   // scenarios
   // ********
   task t_branch;
      logic [7:0]  fl [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h0C};
      logic        tk;
      logic [21:0] ko;
      for (int i = 0; i < 10; i++) for (int s = 0; s < 8; s++) for (int h = 0; h < 2; h++) begin
         wr(6'h20, fl[i]);
         bt <= 3'(s);
         off <= h ? 7'h05 : 7'h7E;
         ko = h ? 22'h000005 : 22'h3FFFFE;
         // the signed index tests n xor v, not the stored bit
         tk = ((s == 4) ? fl[i][2] ^ fl[i][3] : fl[i][s]) == h[0];
         epc = pc_out + (tk ? ko + 22'h1 : 22'h1);
         go(h ? op_branch_on_flag_high : op_branch_on_flag_low);
         chk(pc_out, epc);
         chk(n, tk ? 2 : 1);
      end
      $display("branch test done");
   endtask : t_branch
   task t_skip;
      bsls_op_t so [5] = '{op_equal_skip_compare, op_skip_if_reg_bit_low, op_skip_if_reg_bit_high,
         op_skip_if_io_bit_low, op_skip_if_io_bit_high};
      logic     sk;
      wr(6'h20, 8'hA5);
      wr(6'h02, 8'h10);
      rd <= 2;
      rr <= 1;
      bt <= 4;
      adr <= 22'h7;
      for (int i = 0; i < 5; i++) for (int v = 0; v < 2; v++) for (int l = 0; l < 2; l++) begin
         wr(6'h01, v ? 8'h10 : 8'h00);
         io_val <= v ? 8'h10 : 8'h00;
         nlong <= l[0];
         sk = (i == 1 || i == 3) ? !v : v[0];
         epc = pc_out + (sk ? 22'(2 + l) : 22'h1);
         go(so[i]);
         chk(pc_out, epc);
         chk(n, sk ? 2 + l : 1);
      end
      chk(io_addr, 22'h7);
      rdc(6'h20, 8'hA5);
      $display("skip test done");
   endtask : t_skip
   task t_data;
      wr(6'h1C, 8'h00);
      wr(6'h1D, 8'h01);
      wr(6'h03, 8'h5A);
      ptr <= 1;
      rr <= 3;
      pm <= pm_post_inc;
      go(op_write_via_pointer);
      chk(n, 1);
      rdc(6'h1C, 8'h01);
      rd <= 4;
      pm <= pm_pre_dec;
      go(op_load_via_pointer);
      chk(n, 2);
      rdc(6'h1C, 8'h00);
      rdc(6'h04, 8'h5A);
      wr(6'h03, 8'hC3);
      pm <= pm_plain;
      disp <= 6'h05;
      go(op_write_pointer_offset);
      rd <= 5;
      go(op_load_pointer_offset);
      chk(n, 2);
      rdc(6'h05, 8'hC3);
      rdc(6'h1C, 8'h00);
      pm <= pm_post_inc;
      rd <= 6;
      go(op_load_via_pointer);
      chk(n, 2);
      rdc(6'h06, 8'h5A);
      rdc(6'h1C, 8'h01);
      adr <= 22'h0120;
      go(op_write_absolute);
      chk(n, 2);
      rd <= 7;
      go(op_load_absolute);
      chk(n, 3);
      rdc(6'h07, 8'hC3);
      wr(6'h03, 8'h96);
      adr <= 22'h4002;
      go(op_write_absolute);
      chk(n > 2, 1);
      go(op_load_absolute);
      chk(n > 3, 1);
      rdc(6'h07, 8'h96);
      $display("data test done");
   endtask : t_data
   task t_misc;
      wr(6'h20, 8'h00);
      wr(6'h01, 8'h10);
      wr(6'h02, 8'h10);
      rd <= 1;
      rr <= 2;
      // carry-in compare keeps z only if it was already set
      go(op_compare_with_carry_in);
      rdc(6'h20, 8'h00);
      go(op_compare_registers);
      chk(n, 1);
      rdc(6'h20, 8'h02);
      imm <= 8'h11;
      go(op_compare_with_constant);
      rdc(6'h20, 8'h35);
      rdc(6'h01, 8'h10);
      rd <= 8;
      rr <= 3;
      go(op_register_copy);
      chk(n, 1);
      rd <= 16;
      imm <= 8'h3C;
      go(op_constant_load);
      chk(n, 1);
      rdc(6'h08, 8'h96);
      rdc(6'h10, 8'h3C);
      rdc(6'h20, 8'h35);
      rd <= 10;
      rr <= 2;
      go(op_register_pair_copy);
      chk(n, 1);
      rdc(6'h0A, 8'h10);
      rdc(6'h0B, 8'h96);
      wr(6'h1E, 8'h34);
      wr(6'h1F, 8'h12);
      go(op_pointer_jump);
      chk(n, 2);
      chk(pc_out, 22'h001234);
      adr <= 22'h000200;
      go(op_call_absolute);
      chk(n, 4);
      chk(pc_out, 22'h000200);
      go(op_interrupt_exit);
      chk(n, 5);
      chk(pc_out, 22'h001236);
      rdc(6'h20, 8'hB5);
      go(op_call_absolute);
      go(op_subroutine_exit);
      chk(n, 5);
      chk(pc_out, 22'h001238);
      go(op_pointer_subroutine_jump);
      chk(n, 3);
      chk(pc_out, 22'h001234);
      go(op_subroutine_exit);
      chk(n, 5);
      chk(pc_out, 22'h001239);
      rdc(6'h21, 8'hFF);
      $display("misc test done");
   endtask : t_misc
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 0;
      @(posedge clk_sys);
      #1 chk(instr_ready, 1'b1);
      chk(pc_out, 22'h0);
      rdc(6'h21, 8'hFF);
      rdc(6'h22, 8'h03);
      rdc(6'h20, 8'h00);
      rdc(6'h30, 8'h00);
      $display("reset test done");
      t_branch();
      t_skip();
      t_data();
      t_misc();
      results();
   end
endmodule : branch_skip_load_store_exec_test
